// >>> madc_defs.svh
// Address map, register offsets and field positions for the micro address decoder.
// Assumes inclusion by bare name before any module that uses these constants.
`ifndef MADC_DEFS_SVH
`define MADC_DEFS_SVH
`define MADC_FRAME_SIZE 20'h00c00
`define MADC_REG_CLKDBL 16'hf091
`define MADC_REG_PWM 16'hf0b3
`define MADC_REG_AUDLED 16'hf0b9
`define MADC_REG_DRVSW 16'hf0ba
`define MADC_REG_BAUD 16'hf0c0
`define MADC_REG_STRAP 16'hf0c9
`define MADC_REG_SYNTH 16'hf0d8
`define MADC_REG_FRMLO 16'hf0f6
`define MADC_REG_FRMHI 16'hf0f7
`define MADC_REG_PAGE 16'hf0ff
`define MADC_REG_LAST 16'hf0e0
`define MADC_REG_LASTHI 16'hf0e1
`define MADC_REG_START 16'hf0e2
`define MADC_REG_STARTHI 16'hf0e3
`define MADC_BAUD_DBL_BIT 7
`define MADC_BAUD_FIXED 8'h04
`define MADC_SYN_LOCK_BIT 2
`define MADC_SYN_VCO_BIT 3
`define MADC_SYN_CP_BIT 4
`define MADC_SYN_BYP_BIT 5
`define MADC_SYN_MASK 8'h3c
`define MADC_AUD_MASK 8'h3f
`define MADC_BAUD_MASK 8'h7b
`define MADC_RST_BYTE 8'h00
`define MADC_RST_FRAME 9'h000
`define MADC_ZERO_ADDR 20'h00000
`endif

// >>> madc_pkg.sv
// Types shared by the micro address decoder.
// Assumes madc_defs.svh is available for constants.
`default_nettype none
package madc_pkg;
   typedef enum logic [1:0] {MADC_LIN = 2'b00, MADC_FRM = 2'b01, MADC_REG = 2'b11, MADC_UNU = 2'b10} madc_region_t;
   typedef struct packed {
      logic req;
      logic wr;
      logic [19:0] addr;
      logic [7:0] wdata;
   } madc_buf_t;
   typedef struct packed {
      logic unused_pulse_width_select;
      logic ledCtl;
      logic leftMute;
      logic rightMute;
      logic [1:0] chanSel;
   } madc_audio_t;
endpackage
`default_nettype wire

// >>> madc_decode.sv
// Micro address decode, buffer address forming and miscellaneous control registers.
// Assumes a synchronous micro bus with one-cycle strobes and a single 10 MHz clock.
//
// What this block does
// - Low 32k maps linearly onto DRAM buffer
// - Frame window zero: frame times 3k plus offset
// - Second frame window uses frame plus one
// - Third frame window uses frame plus two
// - Unused region reads zero
// - Any write to the doubler register (0xf091) engages clock doubler unless sysReset is high in the same cycle
// - Doubler state readable in baud register
// - Doubler cleared only by system resets
// - Bypass bit powers down synthesizer
// - Lock test floats LED, routes lock
// - Pulse width register does nothing
// - Channel select mixes audio outputs
// - Separate right and left mutes
// - LED bit drives LED active low
// - Tray sensor in bit zero
// - Switch requests read active low
// - Strap register shows eight strap bits
// - Straps sampled from DRAM bus at reset
// - Linear address is offset plus page times 32768
// - Frame past last wraps to start
// - Doubler bit sits in baud register
`include "madc_defs.svh"
`default_nettype none
module madc_decode
   import madc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sysReset,
   // Micro bus
   input wire logic microRd,
   input wire logic microWr,
   input wire logic [15:0] microAddr,
   input wire logic [7:0] microWdata,
   output logic [7:0] microRdata,
   // Buffer manager side
   output madc_buf_t bufReq,
   input wire logic [7:0] bufRdata,
   input wire logic [7:0] dramBusIn,
   // Clock control
   output logic doublerEngaged,
   output logic synthPowerDown,
   output logic vcoTestMode,
   output logic chargePumpTestMode,
   input wire logic synthLocked,
   // Audio and panel
   input wire logic [15:0] audioLeftIn,
   input wire logic [15:0] audioRightIn,
   output logic [15:0] audioLeftOut,
   output logic [15:0] audioRightOut,
   output logic ledOut,
   output logic ledOe,
   input wire logic qChannelIn,
   output logic qChannelDataOut,
   input wire logic trayPosition,
   input wire logic ejectRequest_n,
   input wire logic skipBackwardRequest_n,
   input wire logic skipForwardRequest_n,
   input wire logic playRequest_n
);
   // ****************************************
   // Registers
   // ****************************************
   logic doubler_r;
   logic [7:0] synth_r;
   madc_audio_t audio_r;
   logic [7:0] baud_r;
   logic [7:0] strap_r;
   logic strapTaken_r;
   logic [7:0] frameLo_r;
   logic [8:0] frame_r;
   logic [4:0] page_r;
   logic [8:0] last_r;
   logic [8:0] start_r;
   logic [7:0] rdata_r;
   logic [7:0] lastLo_r;
   logic [7:0] startLo_r;

   // ****************************************
   // Region decode
   // ****************************************
   madc_region_t region;
   logic [1:0] winSel;
   wire isLin = ~microAddr[15];
   wire isReg = (microAddr[15:12] == 4'hf);
   wire isFrm = microAddr[15] & (microAddr[14:12] <= 3'h2);
   assign region = isLin ? MADC_LIN : (isFrm ? MADC_FRM : (isReg ? MADC_REG : MADC_UNU));
   assign winSel = microAddr[13:12];

   // ****************************************
   // Buffer address
   // ****************************************
   wire [9:0] frmSum = {1'b0, frame_r} + {8'h00, winSel};
   wire [9:0] frmOver = frmSum - {1'b0, last_r} - 10'h001;
   wire frmWraps = frmSum > {1'b0, last_r};
   wire [9:0] frmWrapped = {1'b0, start_r} + frmOver;
   wire [8:0] frmEff = frmWraps ? frmWrapped[8:0] : frmSum[8:0];
   wire [19:0] frmBase = 20'(frmEff) * `MADC_FRAME_SIZE;
   wire [19:0] frmAddr = frmBase + {8'h00, microAddr[11:0]};
   wire [19:0] linAddr = {page_r, microAddr[14:0]};
   wire toBuf = (region == MADC_LIN) || (region == MADC_FRM);
   assign bufReq.req = toBuf & (microRd | microWr);
   assign bufReq.wr = microWr;
   assign bufReq.addr = (region == MADC_LIN) ? linAddr : ((region == MADC_FRM) ? frmAddr : `MADC_ZERO_ADDR);
   assign bufReq.wdata = microWdata;

   // ****************************************
   // Register write strobes
   // ****************************************
   wire regWr = microWr & (region == MADC_REG);
   wire wrDbl = regWr & (microAddr == `MADC_REG_CLKDBL);
   wire wrSyn = regWr & (microAddr == `MADC_REG_SYNTH);
   wire wrAud = regWr & (microAddr == `MADC_REG_AUDLED);
   wire wrBaud = regWr & (microAddr == `MADC_REG_BAUD);
   wire wrFrmLo = regWr & (microAddr == `MADC_REG_FRMLO);
   wire wrFrmHi = regWr & (microAddr == `MADC_REG_FRMHI);
   wire wrPage = regWr & (microAddr == `MADC_REG_PAGE);
   wire wrLastLo = regWr & (microAddr == `MADC_REG_LAST);
   wire wrLastHi = regWr & (microAddr == `MADC_REG_LASTHI);
   wire wrStartLo = regWr & (microAddr == `MADC_REG_START);
   wire wrStartHi = regWr & (microAddr == `MADC_REG_STARTHI);

   // ****************************************
   // Doubler and synthesizer
   // ****************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         doubler_r <= 1'b0;
      end else if (sysReset) begin
         doubler_r <= 1'b0;
      end else if (wrDbl) begin
         doubler_r <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         synth_r <= `MADC_RST_BYTE;
      end else if (wrSyn) begin
         synth_r <= microWdata & `MADC_SYN_MASK;
      end
   end

   wire [7:0] audMasked = microWdata & `MADC_AUD_MASK;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         audio_r <= '0;
      end else if (wrAud) begin
         audio_r <= madc_audio_t'(audMasked[5:0]);
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         baud_r <= `MADC_RST_BYTE;
      end else if (wrBaud) begin
         baud_r <= microWdata & `MADC_BAUD_MASK;
      end
   end

   // ****************************************
   // Frame and page pointers
   // ****************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         frameLo_r <= `MADC_RST_BYTE;
         frame_r <= `MADC_RST_FRAME;
      end else begin
         if (wrFrmLo) begin
            frameLo_r <= microWdata;
         end
         if (wrFrmHi) begin
            frame_r <= {microWdata[0], frameLo_r};
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         page_r <= 5'h00;
      end else if (wrPage) begin
         page_r <= microWdata[4:0];
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lastLo_r <= `MADC_RST_BYTE;
         last_r <= `MADC_RST_FRAME;
      end else begin
         if (wrLastLo) begin
            lastLo_r <= microWdata;
         end
         if (wrLastHi) begin
            last_r <= {microWdata[0], lastLo_r};
         end
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         startLo_r <= `MADC_RST_BYTE;
         start_r <= `MADC_RST_FRAME;
      end else begin
         if (wrStartLo) begin
            startLo_r <= microWdata;
         end
         if (wrStartHi) begin
            start_r <= {microWdata[0], startLo_r};
         end
      end
   end

   // ****************************************
   // Strap capture
   // ****************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         strapTaken_r <= 1'b0;
         strap_r <= `MADC_RST_BYTE;
      end else if (!strapTaken_r) begin
         strapTaken_r <= 1'b1;
         strap_r <= dramBusIn;
      end
   end

   // ****************************************
   // Read path
   // ****************************************
   logic [7:0] regRead;
   wire [7:0] baudOr = baud_r | `MADC_BAUD_FIXED;
   wire [7:0] baudRead = {doubler_r, baudOr[6:0]};
   wire [7:0] swRead = {3'h0, playRequest_n, skipForwardRequest_n, skipBackwardRequest_n,
                        ejectRequest_n, trayPosition};
   always_comb begin
      case (microAddr)
         `MADC_REG_SYNTH: regRead = synth_r;
         `MADC_REG_DRVSW: regRead = swRead;
         `MADC_REG_BAUD: regRead = baudRead;
         `MADC_REG_STRAP: regRead = strap_r;
         `MADC_REG_FRMLO: regRead = frame_r[7:0];
         `MADC_REG_FRMHI: regRead = {7'h00, frame_r[8]};
         `MADC_REG_PAGE: regRead = {3'h0, page_r};
         `MADC_REG_PWM: regRead = `MADC_RST_BYTE;
         default: regRead = `MADC_RST_BYTE;
      endcase
   end

   logic [7:0] rdNxt;
   always_comb begin
      case (region)
         MADC_LIN: rdNxt = bufRdata;
         MADC_FRM: rdNxt = bufRdata;
         MADC_REG: rdNxt = regRead;
         MADC_UNU: rdNxt = `MADC_RST_BYTE;
         default: rdNxt = `MADC_RST_BYTE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_r <= `MADC_RST_BYTE;
      end else if (microRd) begin
         rdata_r <= rdNxt;
      end
   end
   assign microRdata = rdata_r;

   // ****************************************
   // Outputs
   // ****************************************
   wire lockTest = synth_r[`MADC_SYN_LOCK_BIT];
   assign doublerEngaged = doubler_r;
   assign synthPowerDown = synth_r[`MADC_SYN_BYP_BIT];
   assign vcoTestMode = synth_r[`MADC_SYN_VCO_BIT];
   assign chargePumpTestMode = synth_r[`MADC_SYN_CP_BIT];
   assign ledOut = ~audio_r.ledCtl;
   assign ledOe = ~lockTest;
   assign qChannelDataOut = lockTest ? synthLocked : qChannelIn;

   wire [15:0] leftMix = audio_r.chanSel[1] ? audioLeftIn : audioRightIn;
   wire [15:0] rightMix = audio_r.chanSel[0] ? audioRightIn : audioLeftIn;
   wire selMute = (audio_r.chanSel == 2'h0);
   logic [15:0] leftOut_r;
   logic [15:0] rightOut_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         leftOut_r <= 16'h0000;
         rightOut_r <= 16'h0000;
      end else begin
         leftOut_r <= (selMute | audio_r.leftMute) ? 16'h0000 : leftMix;
         rightOut_r <= (selMute | audio_r.rightMute) ? 16'h0000 : rightMix;
      end
   end
   assign audioLeftOut = leftOut_r;
   assign audioRightOut = rightOut_r;
endmodule
`default_nettype wire

// >>> madc_decode_checker.sv
// Port assertions for the micro address decoder.
// Assumes it is bound to madc_decode.
`default_nettype none
module madc_decode_checker
   import madc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sysReset,
   // Micro bus
   input wire logic microRd,
   input wire logic microWr,
   input wire logic [15:0] microAddr,
   input wire logic [7:0] microRdata,
   input wire madc_buf_t bufReq,
   // Controls
   input wire logic doublerEngaged,
   input wire logic ledOe,
   input wire logic synthLocked,
   input wire logic qChannelIn,
   input wire logic qChannelDataOut
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // Checks
   // ****
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   wire logic strobe = microRd || microWr;
   a_linear_map: assert property (strobe && !microAddr[15] |-> bufReq.req && bufReq.addr[14:0] == microAddr[14:0])
      else $error("linear address wrong");
   a_frame_offset: assert property (strobe && microAddr[15:12] inside {4'h8, 4'h9, 4'ha} |->
      bufReq.req && bufReq.addr[9:0] == microAddr[9:0])
      else $error("frame offset wrong");
   a_unused_no_req: assert property (microAddr[15:12] inside {[4'hb:4'he]} |-> !bufReq.req)
      else $error("unused region reached buffer");
   a_unused_read_zero: assert property (microRd && microAddr[15:12] inside {[4'hb:4'he]} |=> microRdata == 8'h00)
      else $error("unused region read not zero");
   a_reg_page_local: assert property (microAddr[15:12] == 4'hf |-> !bufReq.req)
      else $error("register page reached buffer");
   a_doubler_engage: assert property (microWr && microAddr == 16'hf091 && !sysReset |=> doublerEngaged)
      else $error("doubler not engaged");
   a_doubler_sticky: assert property (doublerEngaged && !sysReset |=> doublerEngaged)
      else $error("doubler dropped");
   a_doubler_clear: assert property (sysReset |=> !doublerEngaged)
      else $error("doubler not cleared");
   a_baud_status: assert property (microRd && microAddr == 16'hf0c0 |=> microRdata[7] == $past(doublerEngaged))
      else $error("doubler status wrong");
   a_lock_route: assert property (!ledOe |-> qChannelDataOut == synthLocked)
      else $error("lock not routed");
   a_q_normal: assert property (ledOe |-> qChannelDataOut == qChannelIn)
      else $error("q data not passed");
endmodule
bind madc_decode madc_decode_checker madc_decode_checker_inst (.clk(clk), .arst_n(arst_n), .sysReset(sysReset),
   .microRd(microRd), .microWr(microWr), .microAddr(microAddr), .microRdata(microRdata), .bufReq(bufReq),
   .doublerEngaged(doublerEngaged), .ledOe(ledOe), .synthLocked(synthLocked), .qChannelIn(qChannelIn),
   .qChannelDataOut(qChannelDataOut));
`default_nettype wire

// >>> madc_buf_model.sv
// Buffer manager read model.
// Assumes bufReq is combinational from the micro bus.
`default_nettype none
module madc_buf_model
   import madc_pkg::*;
(
   // Clock
   input wire logic clk,
   // Buffer port
   input wire madc_buf_t bufReq,
   output logic [7:0] bufRdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] idleCnt_r = 8'h00;
   always_ff @(posedge clk) begin
      idleCnt_r <= idleCnt_r + 8'h01;
   end
   // Data from address; idle bus changes each cycle
   assign bufRdata = (bufReq.req && !bufReq.wr) ? (bufReq.addr[7:0] ^ 8'h5a) : idleCnt_r;
endmodule
`default_nettype wire

// >>> madc_decode_tb.sv
// Testbench for the micro address decoder.
// Assumes the buffer model and bound checker are compiled first.
`default_nettype none
module madc_decode_tb import madc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0, arst_n = 1'b0, sysReset = 1'b0, microRd = 1'b0, microWr = 1'b0;
   logic [15:0] microAddr = 16'h0000;
   logic [7:0] microWdata = 8'h00, microRdata, bufRdata, dramBusIn = 8'ha5;
   madc_buf_t bufReq;
   logic doublerEngaged, synthPowerDown, vcoTestMode, chargePumpTestMode, ledOut, ledOe, qChannelDataOut;
   logic synthLocked = 1'b1, qChannelIn = 1'b0, trayPosition = 1'b0, seenReq;
   logic [3:0] panelReq_n = 4'hf;
   logic [15:0] audioLeftIn = 16'h1111, audioRightIn = 16'h2222, audioLeftOut, audioRightOut;
   logic [19:0] seenAddr;
   logic [8:0] seenWr;
   int mismatches = 0, n_compared = 0;
   initial forever #50 clk = ~clk;
   madc_decode madc_decode_inst (.clk(clk), .arst_n(arst_n), .sysReset(sysReset), .microRd(microRd),
      .microWr(microWr), .microAddr(microAddr), .microWdata(microWdata), .microRdata(microRdata), .bufReq(bufReq),
      .bufRdata(bufRdata), .dramBusIn(dramBusIn), .doublerEngaged(doublerEngaged), .synthPowerDown(synthPowerDown),
      .vcoTestMode(vcoTestMode), .chargePumpTestMode(chargePumpTestMode), .synthLocked(synthLocked),
      .audioLeftIn(audioLeftIn), .audioRightIn(audioRightIn), .audioLeftOut(audioLeftOut),
      .audioRightOut(audioRightOut), .ledOut(ledOut), .ledOe(ledOe), .qChannelIn(qChannelIn),
      .qChannelDataOut(qChannelDataOut), .trayPosition(trayPosition), .ejectRequest_n(panelReq_n[0]),
      .skipBackwardRequest_n(panelReq_n[1]), .skipForwardRequest_n(panelReq_n[2]), .playRequest_n(panelReq_n[3]));
   madc_buf_model madc_buf_model_inst (.clk(clk), .bufReq(bufReq), .bufRdata(bufRdata));
   // ****
   // Tasks
   // ****
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic cmp(input string name, input logic [19:0] exp, input logic [19:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask
   task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      microWr <= w;
      microRd <= !w;
      microAddr <= a;
      microWdata <= d;
      #1;
      seenAddr = bufReq.addr;
      seenReq = bufReq.req;
      seenWr = {bufReq.wr, bufReq.wdata};
      @(posedge clk);
      microWr <= 1'b0;
      microRd <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string name);
      io(1'b0, a, 8'h00);
      cmp(name, 20'(exp), 20'(microRdata));
   endtask
   task automatic check_inputs;
      rd(16'hf0c9, 8'ha5, "strap");
      dramBusIn <= 8'h3c;
      trayPosition <= 1'b1;
      panelReq_n <= 4'h5;
      rd(16'hf0c9, 8'ha5, "strap held");
      rd(16'hf0ba, 8'h0b, "switches");
      trayPosition <= 1'b0;
      panelReq_n <= 4'ha;
      rd(16'hf0ba, 8'h14, "switches");
   endtask
   task automatic check_doubler;
      rd(16'hf0c0, 8'h04, "baud idle");
      io(1'b1, 16'hf091, 8'h00);
      rd(16'hf0c0, 8'h84, "baud engaged");
      io(1'b1, 16'hf091, 8'hff);
      rd(16'hf0c0, 8'h84, "baud still");
      sysReset <= 1'b1;
      @(posedge clk);
      sysReset <= 1'b0;
      rd(16'hf0c0, 8'h04, "baud cleared");
   endtask
   task automatic check_windows;
      logic [23:0] w[7] = '{24'hf0ff03, 24'hf0f605, 24'hf0f700, 24'hf0e006, 24'hf0e100, 24'hf0e201, 24'hf0e300};
      logic [15:0] a[4] = '{16'h1234, 16'h8123, 16'h9123, 16'ha123};
      logic [19:0] e[4] = '{20'h19234, 20'h03d23, 20'h04923, 20'h00d23};
      foreach (w[i]) io(1'b1, w[i][23:8], w[i][7:0]);
      for (int i = 0; i < 4; i++) begin
         io(1'b0, a[i], 8'h00);
         cmp("buffer address", e[i], seenAddr);
         cmp("buffer data", 20'(e[i][7:0] ^ 8'h5a), 20'(microRdata));
      end
      io(1'b1, 16'h8010, 8'h77);
      cmp("buffer write address", 20'h03c10, seenAddr);
      cmp("buffer write data", 20'h00177, 20'(seenWr));
   endtask
   task automatic check_unused;
      io(1'b1, 16'hf0b3, 8'hff);
      rd(16'hf0b3, 8'h00, "pwm");
      rd(16'hb000, 8'h00, "unused low");
      cmp("unused req", 20'h0, 20'(seenReq));
      rd(16'hefff, 8'h00, "unused high");
      rd(16'hf0b9, 8'h00, "write only");
   endtask
   task automatic check_synth;
      io(1'b1, 16'hf0d8, 8'h3c);
      cmp("synth test", 20'h1d, 20'({synthPowerDown, vcoTestMode, chargePumpTestMode, ledOe, qChannelDataOut}));
      rd(16'hf0d8, 8'h3c, "synth readback");
      io(1'b1, 16'hf0d8, 8'h20);
      cmp("synth normal", 20'h12, 20'({synthPowerDown, vcoTestMode, chargePumpTestMode, ledOe, qChannelDataOut}));
   endtask
   task automatic check_audio;
      logic [15:0] el, er;
      for (int i = 0; i < 4; i++) begin
         io(1'b1, 16'hf0b9, 8'(i));
         @(posedge clk);
         #1;
         el = (i == 0) ? 16'h0 : (i == 1) ? audioRightIn : audioLeftIn;
         er = (i == 0) ? 16'h0 : (i == 2) ? audioLeftIn : audioRightIn;
         cmp("left out", 20'(el), 20'(audioLeftOut));
         cmp("right out", 20'(er), 20'(audioRightOut));
      end
      cmp("led off", 20'h1, 20'(ledOut));
      io(1'b1, 16'hf0b9, 8'h17);
      @(posedge clk);
      #1;
      cmp("right mute", 20'h01111, {ledOut, 3'h0, audioLeftOut | audioRightOut});
      io(1'b1, 16'hf0b9, 8'h0b);
      @(posedge clk);
      #1;
      cmp("left mute", 20'h82222, {ledOut, 3'h0, audioLeftOut | audioRightOut});
   endtask
   initial begin
      repeat (4) @(posedge clk);
      arst_n <= 1'b1;
      check_inputs;
      check_doubler;
      check_windows;
      check_unused;
      check_synth;
      check_audio;
      stop_test;
   end
   initial begin
      #500000;
      mismatches++;
      stop_test;
   end
endmodule
`default_nettype wire
